//--- hw/cpps_params.svh
// Offsets, field positions, reset values and codes for the privilege and status staging block
`ifndef CPPS_PARAMS_SVH
`define CPPS_PARAMS_SVH

// Register byte offsets
`define CPPS_OFS_CTRL      8'h00
`define CPPS_OFS_PSW       8'h04
`define CPPS_OFS_SYSCFG    8'h08
`define CPPS_OFS_ERRCAP    8'h0C
`define CPPS_OFS_ERRADDR   8'h10
`define CPPS_OFS_IRQSTAT   8'h14
`define CPPS_OFS_IRQMASK   8'h18
`define CPPS_OFS_SBSTAT    8'h1C

// Control register bits: legacy behaviours of the older revision
`define CPPS_CTRL_LEG_PRIV 0
`define CPPS_CTRL_LEG_PRIO 1
`define CPPS_CTRL_LEG_FCD  2
`define CPPS_CTRL_W        3
`define CPPS_CTRL_RST      3'h0

// Status word fields
`define CPPS_PSW_RST       32'h00000800
`define CPPS_IO_PRIVILEGE_FIELD_LO     10
`define CPPS_IO_PRIVILEGE_FIELD_HI     11
`define CPPS_PSW_USR_LO    27
`define CPPS_PSW_USR_HI    31
`define CPPS_USR_W         5

// I/O privilege field codes
`define CPPS_IO_USER0      2'h0
`define CPPS_IO_USER1      2'h1
`define CPPS_IO_SUPV       2'h2

// System configuration bit
`define CPPS_SYSCFG_FCD    0

// Error capture register bits
`define CPPS_ECAP_SUPV     0
`define CPPS_ECAP_WRITE    1
`define CPPS_ECAP_SIZE_LO  2
`define CPPS_ECAP_SIZE_HI  3

// Interrupt status bits
`define CPPS_IRQ_BUSERR    0
`define CPPS_IRQ_FCD       1
`define CPPS_IRQ_PSWREF    2
`define CPPS_IRQ_W         3

`endif

//--- hw/cpps_pkg.sv
// Types shared by the privilege and status staging block
package cpps_pkg;

   // Transfer size code carried with every transaction
   typedef logic [1:0] cpps_size_t;

   // Source of the next bus slot
   typedef enum logic [1:0] {
      CPPS_SRC_NONE,
      CPPS_SRC_DIRECT,
      CPPS_SRC_BUFFER
   } cpps_src_t;

endpackage : cpps_pkg

//--- hw/cpps_sbuf_if.sv
// Carrier between the staging core and its single store buffer entry
`timescale 1ns/100ps
interface cpps_sbuf_if #(
   parameter int AW = 32,
   parameter int DW = 32
);
   logic                 wr_en;
   logic                 clr;
   logic [AW-1:0]        wr_addr;
   logic [DW-1:0]        wr_data;
   cpps_pkg::cpps_size_t wr_size;
   logic                 wr_supv;
   logic                 valid;
   logic [AW-1:0]        rd_addr;
   logic [DW-1:0]        rd_data;
   cpps_pkg::cpps_size_t rd_size;
   logic                 rd_supv;

   modport core (output wr_en, clr, wr_addr, wr_data, wr_size, wr_supv,
                 input  valid, rd_addr, rd_data, rd_size, rd_supv);
   modport mem  (input  wr_en, clr, wr_addr, wr_data, wr_size, wr_supv,
                 output valid, rd_addr, rd_data, rd_size, rd_supv);
endinterface : cpps_sbuf_if

//--- hw/cpps_sbuf.sv
// Single-entry store buffer holding address, data, size and privilege
`timescale 1ns/100ps
module cpps_sbuf (
   // Clock and reset
   input wire logic   clk,
   input wire logic   rstn,
   // Entry port
   cpps_sbuf_if.mem   sb
);

   // Entry contents; a write in the commit cycle replaces the drained entry
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sb.valid   <= 1'b0;
         sb.rd_addr <= '0;
         sb.rd_data <= '0;
         sb.rd_size <= '0;
         sb.rd_supv <= 1'b0;
      end else if (sb.wr_en) begin
         sb.valid   <= 1'b1;
         sb.rd_addr <= sb.wr_addr;
         sb.rd_data <= sb.wr_data;
         sb.rd_size <= sb.wr_size;
         sb.rd_supv <= sb.wr_supv;   // Privilege staged with the store
      end else if (sb.clr) begin
         sb.valid   <= 1'b0;
      end
   end

endmodule : cpps_sbuf

//--- hw/cpps_core.sv
// Privilege tagging of load/store transactions and status word update resolution
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "cpps_params.svh"

// Function
// - Every load/store bus transaction carries a supervisor flag from the status privilege field.
// - Address, size and data come from the issuing instruction and travel with it.
// - Legacy mode reads privilege live from the status word at buffered commit.
// - Both user levels map to one user tag on the bus.
// - Loads go out at once; status word moves from user mode are refused.
// - Legacy mode lets a dual-issued multiply-family update override the move's user bits.
// - Depletion trap entry sets the config flag; legacy mode may skip it.
// - Captured privilege bit reads 0 for user, 1 for supervisor transfers.
// - One buffer entry; store before load parks, commits on next store or idle.
module cpps_core #(
   parameter int AW = 32,
   parameter int DW = 32
) (
   // Clock and reset
   input  wire logic                 CLK,
   input  wire logic                 RSTN,
   // Load/store issue
   input  wire logic                 LS_VALID,
   input  wire logic                 LS_STORE,
   input  wire logic                 LS_NEXT_LOAD,
   input  wire logic [AW-1:0]        LS_ADDR,
   input  wire logic [DW-1:0]        LS_WDATA,
   input  wire cpps_pkg::cpps_size_t LS_SIZE,
   // Status word updates
   input  wire logic                 MTCR_PSW,
   input  wire logic [31:0]          MTCR_DATA,
   input  wire logic                 IP_PSW_WR,
   input  wire logic                 IP_MULFAM,
   input  wire logic [4:0]           IP_USER_BITS,
   // Trap entry
   input  wire logic                 FCD_TRAP,
   input  wire logic                 CSA_CACHEABLE,
   input  wire logic                 CSA_LOCAL_DATA_RAM,
   // Bus error report for the transaction on the bus outputs
   input  wire logic                 BUS_ERR,
   // Register port
   input  wire logic [7:0]           REG_ADDR,
   input  wire logic [31:0]          REG_WDATA,
   input  wire logic                 REG_WR,
   input  wire logic                 REG_RD,
   output logic      [31:0]          REG_RDATA,
   // System bus request
   output logic                      BUS_REQ,
   output logic                      BUS_WRITE,
   output logic      [AW-1:0]        BUS_ADDR,
   output logic      [DW-1:0]        BUS_WDATA,
   output cpps_pkg::cpps_size_t      BUS_SIZE,
   output logic                      BUS_SUPV,
   // Status and interrupt
   output logic      [31:0]          PSW_OUT,
   output logic                      IRQ
);

   // Architectural state
   logic [31:0]                  processor_status_word;
   logic [`CPPS_CTRL_W-1:0]      ctrl;
   logic                         fcd_flag;
   logic [31:0]                  errcap;
   logic [AW-1:0]                erraddr;
   logic [`CPPS_IRQ_W-1:0]       irq_stat;
   logic [`CPPS_IRQ_W-1:0]       irq_mask;

   // Store buffer entry
   cpps_sbuf_if #(.AW(AW), .DW(DW)) sb ();

   cpps_sbuf u_sbuf (
      .clk  (CLK),
      .rstn (RSTN),
      .sb   (sb)
   );

   // Privilege of the running code; user0 and user1 fold to one user tag
   wire [1:0] cur_io   = processor_status_word[`CPPS_IO_PRIVILEGE_FIELD_HI:`CPPS_IO_PRIVILEGE_FIELD_LO];
   wire       cur_supv = (cur_io == `CPPS_IO_SUPV);

   // Slot decode: one bus transaction per cycle
   wire ld        = LS_VALID & ~LS_STORE;
   wire st        = LS_VALID & LS_STORE;
   wire commit_sb = sb.valid & (st | ~LS_VALID);
   wire park      = st & (sb.valid | LS_NEXT_LOAD);
   wire direct    = ld | (st & ~park);                       // Loads never wait

   cpps_pkg::cpps_src_t src;
   assign src = commit_sb ? cpps_pkg::CPPS_SRC_BUFFER :
                direct    ? cpps_pkg::CPPS_SRC_DIRECT : cpps_pkg::CPPS_SRC_NONE;

   // Buffered commit privilege: staged copy, or live word in legacy mode
   wire leg_priv = ctrl[`CPPS_CTRL_LEG_PRIV];
   wire sb_supv  = leg_priv ? cur_supv : sb.rd_supv;

   // Next bus fields; attributes follow the instruction that owns the slot
   wire                 next_req   = (src != cpps_pkg::CPPS_SRC_NONE);
   wire                 next_write = (src == cpps_pkg::CPPS_SRC_BUFFER) | st;
   wire [AW-1:0]        next_addr  = commit_sb ? sb.rd_addr : LS_ADDR;
   wire [DW-1:0]        next_wdata = commit_sb ? sb.rd_data :
                                     (st ? LS_WDATA : '0);
   cpps_pkg::cpps_size_t next_size;
   assign next_size = commit_sb ? sb.rd_size : LS_SIZE;
   wire                 next_supv  = commit_sb ? sb_supv : cur_supv;

   // Buffer write and drain
   assign sb.wr_en   = park;
   assign sb.clr     = commit_sb;
   assign sb.wr_addr = LS_ADDR;
   assign sb.wr_data = LS_WDATA;
   assign sb.wr_size = LS_SIZE;
   assign sb.wr_supv = cur_supv;                              // Latched at park time

   // Bus outputs registered; idle slots show zero
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         BUS_REQ   <= 1'b0;
         BUS_WRITE <= 1'b0;
         BUS_ADDR  <= '0;
         BUS_WDATA <= '0;
         BUS_SIZE  <= '0;
         BUS_SUPV  <= 1'b0;
      end else begin
         BUS_REQ   <= next_req;
         BUS_WRITE <= next_req & next_write;
         BUS_ADDR  <= next_req ? next_addr : '0;
         BUS_WDATA <= next_req ? next_wdata : '0;
         BUS_SIZE  <= next_req ? next_size : '0;
         BUS_SUPV  <= next_req & next_supv;
      end
   end

   // Status word update: user code may not move into it
   wire psw_refuse = MTCR_PSW & ~cur_supv;
   wire psw_move   = MTCR_PSW & cur_supv;
   wire leg_prio   = ctrl[`CPPS_CTRL_LEG_PRIO];
   // Legacy mode reproduces the faulty dual-issue priority for comparison
   wire ip_wins    = psw_move & IP_PSW_WR & IP_MULFAM & leg_prio;

   logic [31:0] next_psw;
   always_comb begin
      next_psw = processor_status_word;
      if (psw_move) begin
         next_psw = MTCR_DATA;                                // Later move wins
         if (ip_wins) begin
            next_psw[`CPPS_PSW_USR_HI:`CPPS_PSW_USR_LO] = IP_USER_BITS;
         end
      end else if (IP_PSW_WR) begin
         next_psw[`CPPS_PSW_USR_HI:`CPPS_PSW_USR_LO] = IP_USER_BITS;
      end
   end

   // Status word register and its copy on the port
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         processor_status_word     <= `CPPS_PSW_RST;
         PSW_OUT <= `CPPS_PSW_RST;
      end else begin
         processor_status_word     <= next_psw;
         PSW_OUT <= next_psw;
      end
   end

   // Register decode
   wire wr_ctrl    = REG_WR & (REG_ADDR == `CPPS_OFS_CTRL);
   wire wr_syscfg  = REG_WR & (REG_ADDR == `CPPS_OFS_SYSCFG);
   wire wr_irqstat = REG_WR & (REG_ADDR == `CPPS_OFS_IRQSTAT);
   wire wr_irqmask = REG_WR & (REG_ADDR == `CPPS_OFS_IRQMASK);

   // Depletion flag; legacy mode drops it for cacheable or local-RAM save areas
   wire fcd_lost = ctrl[`CPPS_CTRL_LEG_FCD] & (CSA_CACHEABLE | CSA_LOCAL_DATA_RAM);
   wire fcd_set  = FCD_TRAP & ~fcd_lost;
   // Trap entry beats a software clear in the same cycle
   wire next_fcd = fcd_set | (wr_syscfg ? REG_WDATA[`CPPS_SYSCFG_FCD] : fcd_flag);

   // Error capture of the transfer now on the bus
   logic [31:0] next_errcap;
   always_comb begin
      next_errcap = errcap;
      if (BUS_ERR) begin
         next_errcap = '0;
         next_errcap[`CPPS_ECAP_SUPV]  = BUS_SUPV;           // 1 supervisor, 0 user
         next_errcap[`CPPS_ECAP_WRITE] = BUS_WRITE;
         next_errcap[`CPPS_ECAP_SIZE_HI:`CPPS_ECAP_SIZE_LO] = BUS_SIZE;
      end
   end

   // Interrupt events; a new event beats the write-one clear
   wire [`CPPS_IRQ_W-1:0] irq_evt = {psw_refuse, FCD_TRAP, BUS_ERR};
   wire [`CPPS_IRQ_W-1:0] irq_clr = wr_irqstat ? REG_WDATA[`CPPS_IRQ_W-1:0] : '0;
   wire [`CPPS_IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_evt;

   // Control, configuration and error capture registers
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         ctrl     <= `CPPS_CTRL_RST;
         fcd_flag <= 1'b0;
         errcap   <= '0;
         erraddr  <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= REG_WDATA[`CPPS_CTRL_W-1:0];
         end
         fcd_flag <= next_fcd;
         errcap   <= next_errcap;
         if (BUS_ERR) begin
            erraddr <= BUS_ADDR;
         end
      end
   end

   // Interrupt status, mask and level output
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         irq_stat <= '0;
         irq_mask <= '0;
         IRQ      <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         if (wr_irqmask) begin
            irq_mask <= REG_WDATA[`CPPS_IRQ_W-1:0];
         end
         IRQ <= |(next_irq_stat & (wr_irqmask ? REG_WDATA[`CPPS_IRQ_W-1:0] : irq_mask));
      end
   end

   // Read mux; unmapped offsets read zero
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h00000000;
      unique case (REG_ADDR)
         `CPPS_OFS_CTRL:    rd_mux[`CPPS_CTRL_W-1:0] = ctrl;
         `CPPS_OFS_PSW:     rd_mux = processor_status_word;
         `CPPS_OFS_SYSCFG:  rd_mux[`CPPS_SYSCFG_FCD] = fcd_flag;
         `CPPS_OFS_ERRCAP:  rd_mux = errcap;
         `CPPS_OFS_ERRADDR: rd_mux[AW-1:0] = erraddr;
         `CPPS_OFS_IRQSTAT: rd_mux[`CPPS_IRQ_W-1:0] = irq_stat;
         `CPPS_OFS_IRQMASK: rd_mux[`CPPS_IRQ_W-1:0] = irq_mask;
         `CPPS_OFS_SBSTAT:  rd_mux[1:0] = {sb.rd_supv, sb.valid};
         default:           rd_mux = 32'h00000000;
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         REG_RDATA <= 32'h00000000;
      end else begin
         REG_RDATA <= REG_RD ? rd_mux : 32'h00000000;
      end
   end

endmodule : cpps_core

//--- tb/cpps_core_monitor.sv
// Port-level assertions for the privilege and status staging core
`timescale 1ns/100ps
`include "cpps_params.svh"
module cpps_core_monitor #(
   parameter int AW = 32
) (
   // Clock and reset
   input wire logic          CLK,
   input wire logic          RSTN,
   // Issue and status inputs
   input wire logic          LS_VALID,
   input wire logic          LS_STORE,
   input wire logic [AW-1:0] LS_ADDR,
   input wire logic          MTCR_PSW,
   input wire logic [31:0]   MTCR_DATA,
   input wire logic          IP_PSW_WR,
   input wire logic [4:0]    IP_USER_BITS,
   input wire logic [7:0]    REG_ADDR,
   input wire logic          REG_RD,
   // Outputs watched
   input wire logic [31:0]   REG_RDATA,
   input wire logic          BUS_REQ,
   input wire logic          BUS_WRITE,
   input wire logic [AW-1:0] BUS_ADDR,
   input wire logic          BUS_SUPV,
   input wire logic [31:0]   PSW_OUT
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   // Only code 2 is supervisor; both user codes look alike
   wire supv = PSW_OUT[11:10] == `CPPS_IO_SUPV;

   property p_idle; !BUS_REQ |-> !BUS_WRITE && !BUS_SUPV && BUS_ADDR == '0; endproperty
   a_idle: assert property (p_idle) else $error("bus fields set while idle");
   property p_load; LS_VALID && !LS_STORE |=> BUS_REQ && !BUS_WRITE
      && BUS_ADDR == $past(LS_ADDR); endproperty
   a_load: assert property (p_load) else $error("load not issued next cycle");
   property p_lsupv; LS_VALID && !LS_STORE |=> BUS_SUPV == $past(supv); endproperty
   a_lsupv: assert property (p_lsupv) else $error("load privilege wrong");
   property p_rdidle; !$past(REG_RD) |-> REG_RDATA == '0; endproperty
   a_rdidle: assert property (p_rdidle) else $error("read data outside slot");
   property p_refuse; MTCR_PSW && !IP_PSW_WR && !supv |=> $stable(PSW_OUT); endproperty
   a_refuse: assert property (p_refuse) else $error("user move changed status");
   property p_move; MTCR_PSW && !IP_PSW_WR && supv |=> PSW_OUT == $past(MTCR_DATA);
   endproperty
   a_move: assert property (p_move) else $error("move not taken");
   property p_ip; IP_PSW_WR && !MTCR_PSW |=>
      PSW_OUT == {$past(IP_USER_BITS), $past(PSW_OUT[26:0])}; endproperty
   a_ip: assert property (p_ip) else $error("user bits update wrong");
   property p_rdpsw; REG_RD && REG_ADDR == `CPPS_OFS_PSW |=> REG_RDATA == $past(PSW_OUT);
   endproperty
   a_rdpsw: assert property (p_rdpsw) else $error("status readback wrong");
endmodule : cpps_core_monitor

bind cpps_core cpps_core_monitor #(.AW(AW)) i_mon (.CLK(CLK), .RSTN(RSTN),
   .LS_VALID(LS_VALID), .LS_STORE(LS_STORE), .LS_ADDR(LS_ADDR), .MTCR_PSW(MTCR_PSW),
   .MTCR_DATA(MTCR_DATA), .IP_PSW_WR(IP_PSW_WR), .IP_USER_BITS(IP_USER_BITS),
   .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .BUS_REQ(BUS_REQ),
   .BUS_WRITE(BUS_WRITE), .BUS_ADDR(BUS_ADDR), .BUS_SUPV(BUS_SUPV), .PSW_OUT(PSW_OUT));

//--- tb/cpps_bus_model.sv
// Behavioural system bus with error trigger and transaction log
`timescale 1ns/100ps
module cpps_bus_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Request from the core
   input  wire logic        req,
   input  wire logic        write,
   input  wire logic [31:0] addr,
   input  wire logic        supv,
   // Error injection
   input  wire logic        err_en,
   input  wire logic [31:0] err_addr,
   output logic             err,
   // Last transaction seen
   output logic [31:0]      last_addr,
   output logic             last_write,
   output logic             last_supv,
   output logic [31:0]      count
);
   // Error must answer the slot shown in this very cycle
   assign err = req && err_en && (addr == err_addr);
   // Every slot is accepted, the bus never stalls
   always_ff @(posedge clk) begin
      if (!rstn) begin
         count <= '0;
      end else if (req) begin
         count      <= count + 32'h1;
         last_addr  <= addr;
         last_write <= write;
         last_supv  <= supv;
      end
   end
endmodule : cpps_bus_model

//--- tb/cpps_core_bench.sv
// Self-checking bench for the privilege and status staging core
`timescale 1ns/100ps
`include "cpps_params.svh"
module cpps_core_bench;
   logic CLK = 0, RSTN = 0, LS_VALID = 0, LS_STORE = 0, LS_NEXT_LOAD = 0, MTCR_PSW = 0;
   logic IP_PSW_WR = 0, IP_MULFAM = 0, FCD_TRAP = 0, CSA_CACHEABLE = 0, CSA_LOCAL_DATA_RAM = 0;
   logic REG_WR = 0, REG_RD = 0, err_en = 0, BUS_REQ, BUS_WRITE, BUS_SUPV, IRQ, BUS_ERR;
   logic [31:0] LS_ADDR = 0, LS_WDATA = 0, MTCR_DATA = 0, REG_WDATA = 0, err_addr = 0;
   logic [31:0] REG_RDATA, BUS_ADDR, BUS_WDATA, PSW_OUT, l_addr, l_cnt;
   logic [7:0]  REG_ADDR = 0;
   logic [4:0]  IP_USER_BITS = 0;
   logic        l_wr, l_supv;
   cpps_pkg::cpps_size_t LS_SIZE = 0, BUS_SIZE;
   int mismatches = 0, compares = 0, cycles = 0;

   cpps_core i_dut (.CLK(CLK), .RSTN(RSTN), .LS_VALID(LS_VALID), .LS_STORE(LS_STORE),
      .LS_NEXT_LOAD(LS_NEXT_LOAD), .LS_ADDR(LS_ADDR), .LS_WDATA(LS_WDATA), .LS_SIZE(LS_SIZE),
      .MTCR_PSW(MTCR_PSW), .MTCR_DATA(MTCR_DATA), .IP_PSW_WR(IP_PSW_WR),
      .IP_MULFAM(IP_MULFAM), .IP_USER_BITS(IP_USER_BITS), .FCD_TRAP(FCD_TRAP),
      .CSA_CACHEABLE(CSA_CACHEABLE), .CSA_LOCAL_DATA_RAM(CSA_LOCAL_DATA_RAM), .BUS_ERR(BUS_ERR),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_RDATA(REG_RDATA), .BUS_REQ(BUS_REQ), .BUS_WRITE(BUS_WRITE), .BUS_ADDR(BUS_ADDR),
      .BUS_WDATA(BUS_WDATA), .BUS_SIZE(BUS_SIZE), .BUS_SUPV(BUS_SUPV), .PSW_OUT(PSW_OUT),
      .IRQ(IRQ));
   cpps_bus_model i_bus (.clk(CLK), .rstn(RSTN), .req(BUS_REQ), .write(BUS_WRITE),
      .addr(BUS_ADDR), .supv(BUS_SUPV), .err_en(err_en), .err_addr(err_addr), .err(BUS_ERR),
      .last_addr(l_addr), .last_write(l_wr), .last_supv(l_supv), .count(l_cnt));

   // Free-running 250 MHz clock and a hang guard
   always #2 CLK = ~CLK;
   always @(posedge CLK) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         wrap_up();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rst();
      RSTN <= 0;
      repeat (3) @(posedge CLK);
      RSTN <= 1;
   endtask : rst
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      REG_ADDR  <= a;
      REG_WDATA <= d;
      REG_WR    <= 1;
      @(posedge CLK);
      REG_WR <= 0;
   endtask : wr
   // Read data is only valid in the slot right after the strobe
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_RD   <= 1;
      @(posedge CLK);
      REG_RD <= 0;
      #1 chk(REG_RDATA, exp);
   endtask : rdc
   task automatic mv(input logic [31:0] d);
      @(posedge CLK);
      MTCR_PSW  <= 1;
      MTCR_DATA <= d;
      @(posedge CLK);
      MTCR_PSW <= 0;
   endtask : mv
   task automatic ld(input logic [31:0] a);
      @(posedge CLK);
      LS_VALID <= 1;
      LS_ADDR  <= a;
      LS_SIZE  <= 2'h2;
      @(posedge CLK);
      LS_VALID <= 0;
   endtask : ld

   task automatic t_reg();
      rst();
      rdc(`CPPS_OFS_PSW, `CPPS_PSW_RST);
      rdc(`CPPS_OFS_CTRL, 32'h0);
      wr(`CPPS_OFS_PSW, 32'h0);
      rdc(`CPPS_OFS_PSW, `CPPS_PSW_RST);
      rdc(8'h20, 32'h0);
      $display("test registers done");
   endtask : t_reg
   // Store parked behind a load while privilege drops to user; sync waits for the drain
   task automatic t_priv(input logic leg, input logic sync);
      rst();
      wr(`CPPS_OFS_CTRL, {31'h0, leg});
      @(posedge CLK);
      {LS_VALID, LS_STORE, LS_NEXT_LOAD, LS_ADDR} <= {3'h7, 32'h100};
      {LS_WDATA, LS_SIZE} <= {32'h5A5A0001, 2'h1};
      @(posedge CLK);
      {LS_STORE, LS_NEXT_LOAD, LS_ADDR, MTCR_PSW, MTCR_DATA} <= {2'h0, 32'h200, !sync, 32'h0};
      @(posedge CLK);
      LS_VALID <= 0;
      MTCR_PSW <= 0;
      #1 chk(BUS_ADDR, 32'h200);
      chk(BUS_WDATA, 32'h0);
      @(posedge CLK);
      MTCR_PSW <= sync; // Barrier case: move only once the buffer drains
      #1 chk(BUS_WDATA, 32'h5A5A0001);
      chk({30'h0, BUS_SIZE}, 32'h1);
      @(posedge CLK);
      MTCR_PSW <= 0;
      @(posedge CLK);
      #1 chk(l_cnt, 32'h2);
      chk(l_addr, 32'h100);
      chk({31'h0, l_wr}, 32'h1);
      chk({31'h0, l_supv}, {31'h0, sync | !leg});
      $display("test parked privilege done");
   endtask : t_priv
   task automatic t_irq();
      wr(`CPPS_OFS_IRQMASK, 32'h7);
      mv(32'h800);
      @(posedge CLK);
      #1 chk(PSW_OUT, 32'h0);
      chk(IRQ, 1);
      rdc(`CPPS_OFS_IRQSTAT, 32'h4);
      wr(`CPPS_OFS_IRQSTAT, 32'h4);
      @(posedge CLK);
      #1 chk(IRQ, 0);
      $display("test interrupt done");
   endtask : t_irq
   // Multiply-family update dual-issued with a status move
   task automatic t_dual(input logic leg);
      rst();
      wr(`CPPS_OFS_CTRL, leg ? 32'h2 : 32'h0);
      @(posedge CLK);
      {IP_PSW_WR, IP_USER_BITS} <= {1'h1, 5'h15};
      @(posedge CLK);
      {IP_USER_BITS, IP_MULFAM, MTCR_PSW, MTCR_DATA} <= {5'h1F, 2'h3, 32'hA00};
      @(posedge CLK);
      {IP_PSW_WR, IP_MULFAM, MTCR_PSW} <= 3'h0;
      #1 chk(PSW_OUT, leg ? 32'hF8000A00 : 32'h00000A00);
      // Compliant software: one no-op slot between the pair keeps the move's bits
      @(posedge CLK);
      {IP_PSW_WR, IP_MULFAM} <= 2'h3;
      @(posedge CLK);
      {IP_PSW_WR, IP_MULFAM} <= 2'h0; // No-op slot
      @(posedge CLK);
      {MTCR_PSW, MTCR_DATA} <= {1'h1, 32'h900};
      @(posedge CLK);
      MTCR_PSW <= 0;
      #1 chk(PSW_OUT, 32'h00000900);
      $display("test dual issue done");
   endtask : t_dual
   task automatic t_fcd(input logic leg);
      rst();
      wr(`CPPS_OFS_CTRL, leg ? 32'h4 : 32'h0);
      @(posedge CLK);
      {FCD_TRAP, CSA_CACHEABLE, CSA_LOCAL_DATA_RAM} <= {1'h1, !leg, leg};
      @(posedge CLK);
      FCD_TRAP <= 0;
      rdc(`CPPS_OFS_SYSCFG, {31'h0, !leg});
      rdc(`CPPS_OFS_IRQSTAT, 32'h2);
      // Trap entry landing on a software clear still leaves the flag set
      @(posedge CLK);
      {FCD_TRAP, CSA_LOCAL_DATA_RAM, REG_WR, REG_ADDR, REG_WDATA} <= {3'h5, `CPPS_OFS_SYSCFG, 32'h0};
      @(posedge CLK);
      {FCD_TRAP, REG_WR} <= 2'h0;
      rdc(`CPPS_OFS_SYSCFG, 32'h1);
      wr(`CPPS_OFS_SYSCFG, 32'h0);
      rdc(`CPPS_OFS_SYSCFG, 32'h0);
      $display("test depletion flag done");
   endtask : t_fcd
   task automatic t_err();
      rst();
      err_addr <= 32'h300;
      err_en   <= 1;
      ld(32'h300);
      rdc(`CPPS_OFS_ERRCAP, 32'h9);
      rdc(`CPPS_OFS_ERRADDR, 32'h300);
      mv(32'h400);
      ld(32'h300);
      rdc(`CPPS_OFS_ERRCAP, 32'h8);
      err_en <= 0;
      $display("test error capture done");
   endtask : t_err

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up

   initial begin
      t_reg();
      t_priv(0, 0);
      t_irq();
      t_priv(1, 0);
      t_priv(1, 1);
      t_dual(0);
      t_dual(1);
      t_fcd(0);
      t_fcd(1);
      t_err();
      wrap_up();
   end
endmodule : cpps_core_bench
